// ### hw/mitc_pkg.sv
// constants shared by the instruction timing core and its helpers
// assumes one 50 MHz clock and an 8-bit data path
`default_nettype none

package mitc_pkg;

    // ************************************************************
    // widths and counts
    // ************************************************************
    localparam int PM_AW = 12;
    localparam int PM_DW = 16;
    localparam int DM_AW = 8;
    localparam int STACK_DEPTH = 8;
    localparam int PHASES = 4;
    localparam logic [1:0] PH_ADDR = 2'h0;
    localparam logic [1:0] PH_READ = 2'h1;
    localparam logic [1:0] PH_CALC = 2'h2;
    localparam logic [1:0] PH_LAST = 2'h3;

    // ************************************************************
    // reset values and special addresses
    // ************************************************************
    localparam logic [11:0] RESET_PC = 12'h000;
    localparam logic [7:0] PCL_ADDR = 8'h06;

    // ************************************************************
    // instruction classes, bits [15:12]
    // ************************************************************
    localparam logic [3:0] OP_MISC = 4'h0;
    localparam logic [3:0] OP_JMP = 4'h1;
    localparam logic [3:0] OP_CALL = 4'h2;
    localparam logic [3:0] OP_ALU_A = 4'h3;
    localparam logic [3:0] OP_ALU_M = 4'h4;
    localparam logic [3:0] OP_ALU_I = 4'h5;
    localparam logic [3:0] OP_BSET = 4'h6;
    localparam logic [3:0] OP_BCLR = 4'h7;
    localparam logic [3:0] OP_SKBS = 4'h8;
    localparam logic [3:0] OP_SKBC = 4'h9;
    localparam logic [3:0] OP_SKZ = 4'ha;
    localparam logic [3:0] OP_TBLP = 4'hb;

    // ************************************************************
    // misc sub-codes, bits [11:8]
    // ************************************************************
    localparam logic [3:0] SUB_NOP = 4'h0;
    localparam logic [3:0] SUB_RET = 4'h1;
    localparam logic [3:0] SUB_INTERRUPT_RETURN_OP = 4'h2;
    localparam logic [3:0] SUB_HALT = 4'h3;
    localparam logic [3:0] SUB_TABRD = 4'h4;
    localparam logic [3:0] SUB_MOV_AM = 4'h5;
    localparam logic [3:0] SUB_MOV_MA = 4'h6;
    localparam logic [3:0] SUB_MOV_AX = 4'h7;
    localparam logic [3:0] SUB_CLRM = 4'h8;

    // ************************************************************
    // alu operations, bits [11:8]
    // ************************************************************
    localparam logic [3:0] ALU_ADD = 4'h0;
    localparam logic [3:0] ALU_ADC = 4'h1;
    localparam logic [3:0] ALU_SUB = 4'h2;
    localparam logic [3:0] ALU_SBC = 4'h3;
    localparam logic [3:0] ALU_AND = 4'h4;
    localparam logic [3:0] ALU_OR = 4'h5;
    localparam logic [3:0] ALU_XOR = 4'h6;
    localparam logic [3:0] ALU_CPL = 4'h7;
    localparam logic [3:0] ALU_INC = 4'h8;
    localparam logic [3:0] ALU_DEC = 4'h9;
    localparam logic [3:0] ALU_RR = 4'ha;
    localparam logic [3:0] ALU_RL = 4'hb;
    localparam logic [3:0] ALU_RRC = 4'hc;
    localparam logic [3:0] ALU_RLC = 4'hd;

endpackage : mitc_pkg

`default_nettype wire

// ### hw/mitc_phase.sv
// four-phase sequencer that splits each instruction cycle
// assumes the single system clock and an active-low async reset
`default_nettype none

module mitc_phase
    import mitc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, low
    output logic [1:0] phase // current phase of the cycle
);

    // ************************************************************
    // phase counter
    // ************************************************************
    // wraps every four clocks, one instruction cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            phase <= PH_ADDR;
        end else begin
            phase <= phase + 2'h1;
        end
    end

endmodule : mitc_phase

`default_nettype wire

// ### hw/mitc_alu.sv
// combinational 8-bit arithmetic, logic and rotate unit
// assumes operands and carry come from registers of the core
`default_nettype none

module mitc_alu
    import mitc_pkg::*;
(
    input wire logic [3:0] op, // operation select
    input wire logic [7:0] a, // accumulator operand
    input wire logic [7:0] b, // memory or immediate operand
    input wire logic cin, // carry flag in
    output logic [7:0] res, // result
    output logic cout, // carry flag out
    output logic cUpd, // carry flag is written
    output logic zUpd // zero flag is written
);

    logic [8:0] wide;

    // ************************************************************
    // operation select
    // ************************************************************
    always_comb begin
        wide = 9'h000;
        res = 8'h00;
        cout = cin;
        cUpd = 1'b0;
        zUpd = 1'b1;
        case (op)
            ALU_ADD, ALU_ADC: begin
                wide = {1'b0, a} + {1'b0, b} + {8'h00, op[0] & cin};
                res = wide[7:0];
                cout = wide[8]; // carry above 255
                cUpd = 1'b1;
            end
            ALU_SUB, ALU_SBC: begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, op[0] & cin};
                res = wide[7:0];
                cout = wide[8]; // borrow below 0
                cUpd = 1'b1;
            end
            ALU_AND: res = a & b;
            ALU_OR: res = a | b;
            ALU_XOR: res = a ^ b;
            ALU_CPL: res = ~b;
            ALU_INC: res = b + 8'h01;
            ALU_DEC: res = b - 8'h01;
            ALU_RR: begin
                res = {b[0], b[7:1]};
                zUpd = 1'b0;
            end
            ALU_RL: begin
                res = {b[6:0], b[7]};
                zUpd = 1'b0;
            end
            ALU_RRC: begin
                res = {cin, b[7:1]};
                cout = b[0]; // outgoing bit to carry
                cUpd = 1'b1;
                zUpd = 1'b0;
            end
            ALU_RLC: begin
                res = {b[6:0], cin};
                cout = b[7];
                cUpd = 1'b1;
                zUpd = 1'b0;
            end
            default: begin
                res = b;
                zUpd = 1'b0;
            end
        endcase
    end

endmodule : mitc_alu

`default_nettype wire

// ### hw/mitc_core.sv
// 8-bit core: fetch, decode, execute with four-phase cycles
// assumes program and data memory answer one clock after address
`default_nettype none

module mitc_core
    import mitc_pkg::*;
#(
    parameter int STACK_N = STACK_DEPTH
)
(
    input wire logic clk, // system clock, 50 MHz
    input wire logic rstn, // async reset, low
    output logic [PM_AW-1:0] pmAddr, // program memory address
    input wire logic [PM_DW-1:0] pmData, // program memory data
    output logic [DM_AW-1:0] dmAddr, // data memory address
    input wire logic [7:0] dmRdData, // data memory read data
    output logic [7:0] dmWrData, // data memory write data
    output logic dmWe, // data memory write enable
    output logic [7:0] tblHigh, // high byte of last table read
    output logic [7:0] accOut, // accumulator
    output logic carryFlag, // carry flag
    output logic zeroFlag, // zero flag
    output logic globalIntEnable, // global interrupt enable
    output logic powerDown, // core halted
    input wire logic wakeUp // leaves power-down
);

    localparam int SP_W = $clog2(STACK_N);

    logic [1:0] phase;
    logic [PM_AW-1:0] pcQ;
    logic [PM_DW-1:0] irQ;
    logic validQ;
    logic tblStallQ;
    logic [7:0] tblDstQ;
    logic [7:0] tblPtrQ;
    logic [7:0] memQ;
    logic [PM_AW-1:0] stackMem [STACK_N];
    logic [SP_W-1:0] spQ;
    logic commit;

    logic [3:0] op;
    logic [3:0] sub;
    logic [7:0] aluB;
    logic [7:0] aluRes;
    logic aluCout;
    logic aluCUpd;
    logic aluZUpd;
    logic [7:0] bitMask;

    logic accWr;
    logic [7:0] accVal;
    logic memWr;
    logic [7:0] memVal;
    logic flagWr;
    logic unconditional_jump_op;
    logic [PM_AW-1:0] jmpTgt;
    logic push;
    logic pop;
    logic skip;
    logic halt;
    logic tbl;
    logic giSet;
    logic ptrWr;
    logic pclWr;

    // ************************************************************
    // helpers
    // ************************************************************
    mitc_phase u_phase (
        .clk(clk),
        .rstn(rstn),
        .phase(phase)
    );

    mitc_alu u_alu (
        .op(sub),
        .a(accOut),
        .b(aluB),
        .cin(carryFlag),
        .res(aluRes),
        .cout(aluCout),
        .cUpd(aluCUpd),
        .zUpd(aluZUpd)
    );

    // operand fields and shared terms
    assign op = irQ[15:12];
    assign sub = irQ[11:8];
    assign aluB = (op == OP_ALU_I) ? irQ[7:0] : memQ;
    assign bitMask = 8'h01 << irQ[10:8];
    assign commit = (phase == PH_LAST) && !powerDown;

    // ************************************************************
    // decode
    // ************************************************************
    // a bubble in irQ decodes to nothing
    always_comb begin
        accWr = 1'b0;
        accVal = aluRes;
        memWr = 1'b0;
        memVal = aluRes;
        flagWr = 1'b0;
        unconditional_jump_op = 1'b0;
        jmpTgt = irQ[PM_AW-1:0];
        push = 1'b0;
        pop = 1'b0;
        skip = 1'b0;
        halt = 1'b0;
        tbl = 1'b0;
        giSet = 1'b0;
        ptrWr = 1'b0;
        if (validQ) begin
            case (op)
                OP_MISC: begin
                    case (sub)
                        SUB_RET, SUB_INTERRUPT_RETURN_OP: begin
                            pop = 1'b1;
                            unconditional_jump_op = 1'b1;
                            jmpTgt = stackMem[spQ - SP_W'(1)];
                            giSet = (sub == SUB_INTERRUPT_RETURN_OP);
                        end
                        SUB_HALT: halt = 1'b1;
                        SUB_TABRD: tbl = 1'b1;
                        SUB_MOV_AM: begin
                            accWr = 1'b1; // register to acc
                            accVal = memQ;
                        end
                        SUB_MOV_MA: begin
                            memWr = 1'b1; // acc to register
                            memVal = accOut;
                        end
                        SUB_MOV_AX: begin
                            accWr = 1'b1; // immediate to acc
                            accVal = irQ[7:0];
                        end
                        SUB_CLRM: begin
                            memWr = 1'b1;
                            memVal = 8'h00;
                        end
                        default: ;
                    endcase
                end
                OP_JMP: unconditional_jump_op = 1'b1; // no return saved
                OP_CALL: begin
                    unconditional_jump_op = 1'b1;
                    push = 1'b1;
                end
                OP_ALU_A, OP_ALU_I: begin
                    accWr = 1'b1;
                    flagWr = 1'b1;
                end
                OP_ALU_M: begin
                    memWr = 1'b1;
                    flagWr = 1'b1;
                end
                OP_BSET: begin
                    memWr = 1'b1;
                    memVal = memQ | bitMask;
                end
                OP_BCLR: begin
                    memWr = 1'b1;
                    memVal = memQ & ~bitMask;
                end
                OP_SKBS: skip = |(memQ & bitMask);
                OP_SKBC: skip = ~|(memQ & bitMask);
                OP_SKZ: skip = (memQ == 8'h00);
                OP_TBLP: ptrWr = 1'b1;
                default: ;
            endcase
        end
        pclWr = memWr && (irQ[7:0] == PCL_ADDR);
    end

    // ************************************************************
    // program counter, instruction register, prefetch
    // ************************************************************
    // flow changes leave a bubble in place of the prefetch
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pcQ <= RESET_PC;
            irQ <= 16'h0000;
            validQ <= 1'b0;
            tblStallQ <= 1'b0;
        end else if (commit) begin
            if (tblStallQ) begin
                tblStallQ <= 1'b0; // second cycle, keeps prefetch
            end else if (unconditional_jump_op) begin
                pcQ <= jmpTgt;
                validQ <= 1'b0; // discard prefetch
            end else if (pclWr) begin
                pcQ <= {pcQ[PM_AW-1:8], memVal}; // acts as jump
                validQ <= 1'b0;
            end else begin
                pcQ <= pcQ + PM_AW'(1);
                irQ <= pmData;
                validQ <= !skip; // taken skip adds a cycle
                tblStallQ <= tbl;
            end
        end
    end

    // ************************************************************
    // return stack
    // ************************************************************
    // pcQ already points past the call
    always_ff @(posedge clk) begin
        if (commit && !tblStallQ && push) begin
            stackMem[spQ] <= pcQ;
        end
    end

    // stack pointer, wraps when overfilled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            spQ <= '0;
        end else if (commit && !tblStallQ) begin
            if (push) begin
                spQ <= spQ + SP_W'(1);
            end else if (pop) begin
                spQ <= spQ - SP_W'(1);
            end
        end
    end

    // ************************************************************
    // memory addressing and operand capture
    // ************************************************************
    // addresses go out at start of cycle, data read one phase on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pmAddr <= RESET_PC;
            dmAddr <= 8'h00;
            memQ <= 8'h00;
        end else if (phase == PH_ADDR) begin
            pmAddr <= tblStallQ ? {pcQ[PM_AW-1:8], tblPtrQ} : pcQ;
            dmAddr <= tblStallQ ? tblDstQ : irQ[7:0];
        end else if (phase == PH_READ) begin
            memQ <= dmRdData;
        end
    end

    // write strobe high through the last phase of the cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            dmWe <= 1'b0;
            dmWrData <= 8'h00;
            tblHigh <= 8'h00;
        end else if (phase == PH_CALC && (!powerDown || wakeUp)) begin
            if (tblStallQ) begin
                dmWe <= 1'b1;
                dmWrData <= pmData[7:0]; // table low byte
                tblHigh <= pmData[15:8];
            end else begin
                dmWe <= memWr && !pclWr;
                dmWrData <= memVal;
            end
        end else begin
            dmWe <= 1'b0;
        end
    end

    // table pointer and destination
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tblPtrQ <= 8'h00;
            tblDstQ <= 8'h00;
        end else if (commit && !tblStallQ) begin
            if (ptrWr) begin
                tblPtrQ <= irQ[7:0];
            end
            if (tbl) begin
                tblDstQ <= irQ[7:0];
            end
        end
    end

    // ************************************************************
    // accumulator and flags
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            accOut <= 8'h00;
            carryFlag <= 1'b0;
            zeroFlag <= 1'b0;
        end else if (commit && !tblStallQ) begin
            if (accWr) begin
                accOut <= accVal;
            end
            if (flagWr && aluCUpd) begin
                carryFlag <= aluCout;
            end
            if (flagWr && aluZUpd) begin
                zeroFlag <= (aluRes == 8'h00);
            end
        end
    end

    // ************************************************************
    // interrupt enable and power-down
    // ************************************************************
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            globalIntEnable <= 1'b0;
            powerDown <= 1'b0;
        end else begin
            if (commit && !tblStallQ && giSet) begin
                globalIntEnable <= 1'b1;
            end
            if (powerDown && wakeUp) begin
                powerDown <= 1'b0;
            end else if (commit && !tblStallQ && halt) begin
                powerDown <= 1'b1;
            end
        end
    end

endmodule : mitc_core

`default_nettype wire

// ### tb/mitc_core_sva.sv
// checker for the instruction timing core, bound to its top ports
// assumes one clock domain and an active-low asynchronous reset
`default_nettype none

module mitc_core_sva
    import mitc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic rstn, // async reset, low
    input wire logic [PM_AW-1:0] pmAddr, // program address
    input wire logic [DM_AW-1:0] dmAddr, // data address
    input wire logic dmWe, // data write strobe
    input wire logic [7:0] accOut, // accumulator
    input wire logic carryFlag, // carry
    input wire logic zeroFlag, // zero
    input wire logic globalIntEnable, // interrupt enable
    input wire logic powerDown, // halted
    input wire logic wakeUp // wake request
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // ************************************************************
    // cycle framing
    // ************************************************************
    property p_pm_hold;
        $changed(pmAddr) |=> $stable(pmAddr) [*3];
    endproperty
    a_pm_hold: assert property (p_pm_hold)
        else $error("program address moved inside a cycle");

    property p_we_gap;
        dmWe |=> !dmWe [*3];
    endproperty
    a_we_gap: assert property (p_we_gap)
        else $error("write strobes closer than four clocks");

    property p_we_late;
        $changed(pmAddr) |-> !dmWe ##1 !dmWe;
    endproperty
    a_we_late: assert property (p_we_late)
        else $error("write strobe outside the last phase");

    property p_we_addr;
        $rose(dmWe) |-> $stable(dmAddr) ##1 $stable(dmAddr);
    endproperty
    a_we_addr: assert property (p_we_addr)
        else $error("data address moved during a write");

    property p_no_pcl_write;
        dmWe |-> dmAddr != PCL_ADDR;
    endproperty
    a_no_pcl_write: assert property (p_no_pcl_write)
        else $error("program counter byte written to data memory");

    // ************************************************************
    // power-down and interrupt enable
    // ************************************************************
    property p_halt_hold;
        powerDown && !wakeUp |=> powerDown;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("power-down left without wake request");

    property p_wake;
        powerDown && wakeUp |=> !powerDown;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake request ignored");

    property p_halt_frozen;
        powerDown && !wakeUp |=> $stable(accOut) && $stable(carryFlag)
            && $stable(zeroFlag) && !dmWe;
    endproperty
    a_halt_frozen: assert property (p_halt_frozen)
        else $error("state changed while powered down");

    property p_gie_keep;
        !$fell(globalIntEnable);
    endproperty
    a_gie_keep: assert property (p_gie_keep)
        else $error("interrupt enable cleared");

    c_halt: cover property ($rose(powerDown));
    c_gie: cover property ($rose(globalIntEnable));
    c_carry_write: cover property (dmWe && carryFlag);
endmodule : mitc_core_sva

`default_nettype wire

// ### tb/mitc_mem_model.sv
// program and data memory facing the core, behavioural
// assumes the bench preloads both arrays while reset is held
`default_nettype none

module mitc_mem_model
    import mitc_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic [PM_AW-1:0] pmAddr, // program address
    output logic [PM_DW-1:0] pmData, // program word
    input wire logic [DM_AW-1:0] dmAddr, // data address
    output logic [7:0] dmRdData, // data read
    input wire logic [7:0] dmWrData, // data to write
    input wire logic dmWe // write strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [PM_DW-1:0] pm [0:4095];
    logic [7:0] dm [0:255];

    // ************************************************************
    // reads answer at once and hold while the address holds
    // ************************************************************
    assign pmData = pm[pmAddr];
    assign dmRdData = dm[dmAddr];

    // write lands at the edge that ends the strobe
    always @(posedge clk) begin
        if (dmWe) begin
            dm[dmAddr] <= dmWrData;
        end
    end
endmodule : mitc_mem_model

`default_nettype wire

// ### tb/tb.sv
// self-checking bench for the instruction timing core
// assumes the memory model and the checker sit beside the core
`default_nettype none

module tb
    import mitc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic wakeUp = 1'b0;
    logic [PM_AW-1:0] pmAddr;
    logic [PM_DW-1:0] pmData;
    logic [DM_AW-1:0] dmAddr;
    logic [7:0] dmRdData, dmWrData, tblHigh, accOut;
    logic dmWe, carryFlag, zeroFlag, globalIntEnable, powerDown;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [15:0] logAd [$];
    logic [2:0] logFl [$];
    int logCy [$];

    always #10 clk = ~clk;

    mitc_core u_mitc_core (
        .clk(clk), .rstn(rstn), .pmAddr(pmAddr), .pmData(pmData),
        .dmAddr(dmAddr), .dmRdData(dmRdData), .dmWrData(dmWrData),
        .dmWe(dmWe), .tblHigh(tblHigh), .accOut(accOut),
        .carryFlag(carryFlag), .zeroFlag(zeroFlag),
        .globalIntEnable(globalIntEnable), .powerDown(powerDown),
        .wakeUp(wakeUp)
    );

    mitc_mem_model u_mitc_mem_model (
        .clk(clk), .pmAddr(pmAddr), .pmData(pmData), .dmAddr(dmAddr),
        .dmRdData(dmRdData), .dmWrData(dmWrData), .dmWe(dmWe)
    );

    // record each data write with enable and flags seen at that edge
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (rstn && dmWe) begin
            logAd.push_back({dmAddr, dmWrData});
            logFl.push_back({globalIntEnable, carryFlag, zeroFlag});
            logCy.push_back(cyc);
        end
    end

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic hold();
        int i;
        @(posedge clk);
        rstn <= 1'b0;
        wakeUp <= 1'b0;
        @(posedge clk);
        logAd.delete();
        logFl.delete();
        logCy.delete();
        for (i = 0; i < 4096; i++) u_mitc_mem_model.pm[i] = 16'h0000;
        for (i = 0; i < 256; i++) u_mitc_mem_model.dm[i] = 8'h00;
        check({pmAddr, accOut, dmWe, powerDown, globalIntEnable}, 32'h0);
    endtask : hold

    task automatic start();
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
    endtask : start

    task automatic wait_log(input int n);
        int k;
        for (k = 0; k < 400 && logAd.size() < n; k++) @(posedge clk);
        check(logAd.size(), n);
    endtask : wait_log

    // ************************************************************
    // flow changes, cycle counts, halt and wake
    // ************************************************************
    task automatic test_flow();
        logic [15:0] p [32];
        logic [15:0] ad [9];
        int gp [9];
        int i;
        p = '{16'h0711, 16'h0620, 16'h1004, 16'h07ee, 16'h0621, 16'h2010,
              16'h0622, 16'h201c, 16'ha020, 16'h0624, 16'ha030, 16'h0625,
              16'h0626, 16'h0714, 16'h0606, 16'h07ee, 16'h0733, 16'h0623,
              16'h0100, 16'h0000, 16'h0627, 16'hb080, 16'h0428, 16'h0629,
              16'h0300, 16'h062a, 16'h0300, 16'h0000, 16'h0200, 16'h0000,
              16'h0000, 16'h0000};
        ad = '{16'h2011, 16'h2111, 16'h2333, 16'h2233, 16'h2433, 16'h2633,
               16'h2714, 16'h285a, 16'h2914};
        gp = '{0, 12, 16, 12, 24, 12, 16, 0, 0};
        hold();
        for (i = 0; i < 32; i++) u_mitc_mem_model.pm[i] = p[i];
        u_mitc_mem_model.pm[12'h080] = 16'ha55a;
        start();
        wait_log(9);
        for (i = 0; i < 9; i++) begin
            check(logAd[i], ad[i]);
            if (gp[i] != 0) begin
                check(logCy[i] - logCy[i-1], gp[i]);
            end
        end
        check(logCy[8] - logCy[6], 16);
        check(tblHigh, 8'ha5);
        check(logFl[3][2], 1'b0);
        check(logFl[4][2], 1'b1);
        for (i = 0; i < 100 && !powerDown; i++) @(posedge clk);
        repeat (40) @(posedge clk);
        check(powerDown, 1'b1);
        check(logAd.size(), 9);
        wakeUp <= 1'b1;
        @(posedge clk);
        wakeUp <= 1'b0;
        wait_log(10);
        check(logAd[9], 16'h2a14);
        $display("test flow done");
    endtask : test_flow

    // ************************************************************
    // arithmetic, logic, rotates, bits and moves
    // ************************************************************
    task automatic test_alu();
        logic [15:0] p [37];
        logic [15:0] ad [18];
        logic [2:0] fl [18];
        int i;
        p = '{16'h0701, 16'h3040, 16'h0650, 16'h5202, 16'h0651, 16'h540f,
              16'h0652, 16'h560e, 16'h0653, 16'h3c41, 16'h0654, 16'h3d42,
              16'h0655, 16'h3a41, 16'h0656, 16'h3b41, 16'h0657, 16'h4840,
              16'h3941, 16'h0658, 16'h6742, 16'h7042, 16'h8742, 16'h0659,
              16'h9142, 16'h065a, 16'h3740, 16'h065b, 16'h5101, 16'h065c,
              16'h5300, 16'h065d, 16'h0700, 16'h5500, 16'h085e, 16'h5530,
              16'h065f};
        ad = '{16'h5000, 16'h51fe, 16'h520e, 16'h5300, 16'h54c0, 16'h551f,
               16'h56c0, 16'h5703, 16'h4000, 16'h5880, 16'h428f, 16'h428e,
               16'h5a80, 16'h5bff, 16'h5c00, 16'h5dff, 16'h5e00, 16'h5f30};
        fl = '{3'h7, 3'h6, 3'h6, 3'h7, 3'h7, 3'h5, 3'h5, 3'h5, 3'h0, 3'h4,
               3'h0, 3'h0, 3'h4, 3'h4, 3'h7, 3'h6, 3'h7, 3'h6};
        hold();
        for (i = 0; i < 37; i++) u_mitc_mem_model.pm[i] = p[i];
        u_mitc_mem_model.dm[8'h40] = 8'hff;
        u_mitc_mem_model.dm[8'h41] = 8'h81;
        u_mitc_mem_model.dm[8'h42] = 8'h0f;
        start();
        wait_log(18);
        for (i = 0; i < 18; i++) begin
            check(logAd[i], ad[i]);
            if (fl[i][2]) begin
                check(logFl[i][1:0], fl[i][1:0]);
            end
        end
        $display("test alu done");
    endtask : test_alu

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : conclude

    // main sequence
    initial begin
        test_flow();
        test_alu();
        conclude();
    end

    // watchdog against a hung core
    initial begin
        repeat (6000) @(posedge clk);
        n_fail++;
        $display("watchdog expired at %0t", $time);
        conclude();
    end
endmodule : tb

bind mitc_core mitc_core_sva u_mitc_core_sva (
    .clk(clk), .rstn(rstn), .pmAddr(pmAddr), .dmAddr(dmAddr), .dmWe(dmWe),
    .accOut(accOut), .carryFlag(carryFlag), .zeroFlag(zeroFlag),
    .globalIntEnable(globalIntEnable), .powerDown(powerDown), .wakeUp(wakeUp)
);

`default_nettype wire
